// file: segmap_pkg.sv
// Constants and types shared by the program address segment map
package segmap_pkg;
  localparam logic [7:0] WIDTH_OFS = 8'h00;
  localparam logic [7:0] CTRL_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] MASK_OFS = 8'h0C;
  localparam logic [7:0] STATE_OFS = 8'h10;
  localparam logic [27:0] WIDTH_RST = 28'h0000000;
  localparam logic CTRL_RST = 1'h0;
  localparam logic [1:0] MASK_RST = 2'h0;
  // Port width codes, two bits per subsegment
  localparam logic [1:0] PW32 = 2'h0;
  localparam logic [1:0] PW16 = 2'h1;
  localparam logic [1:0] PW8 = 2'h2;
  // Access size codes
  localparam logic [1:0] SZ_B = 2'h0;
  localparam logic [1:0] SZ_H = 2'h1;
  localparam logic [1:0] SZ_W = 2'h2;
  localparam logic [31:0] USER_OFFSET = 32'h40000000;
  localparam logic [31:0] GAP_LO = 32'h20000000;
  localparam logic [31:0] GAP_HI = 32'h3FFFFFFF;
  localparam logic [3:0] SUB_USER = 4'h8;
  localparam logic [3:0] SUB_MAPPED = 4'hC;
  localparam int EV_TRAP = 0;
  localparam int EV_ILL = 1;
  localparam int NUM_EV = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic {ST_IDLE, ST_BUSY} xfer_state_t;
endpackage

// file: segment_map.sv
// Program address segment map with port width splitting and AXI4-Lite regs
`timescale 1ns/10ps
`default_nettype none
// Function
// R01 - User mode: privileged or barred coprocessor illegal
// R02 - Mode permits only; translation is mode independent
// R03 - Both lower kernel segments map low 512M
// R04 - User segment adds 1GB offset
// R05 - Mapped kernel segment passes address unchanged
// R06 - Never emit physical 0x20000000 to 0x3FFFFFFF
// R07 - Word to narrow region splits into phases
// R08 - Widths 8, 16 or 32, automatic sequencing
// R09 - Low region: eight 64M subsegment widths
// R10 - User segment: four 512M subsegment widths
// R11 - Mapped kernel: two 512M subsegment widths
// R12 - Cached kernel clears top bit, cached
// R13 - Uncached kernel clears three top bits
// R14 - User access with top bit traps
// R15 - Reset enters kernel mode
// R16 - Fourteen two-bit widths, used next access
module segment_map (
  input wire logic clk, // Processor clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic user_mode, // Pipeline mode, 1 = user
  input wire logic req_valid, // Access request
  output logic req_ready, // Block can take a request
  input wire logic [31:0] req_addr, // Program address
  input wire logic [1:0] req_size, // Access size code
  input wire logic req_write, // Store
  input wire logic req_cop, // Access to system control coprocessor
  input wire logic req_priv, // Instruction outside user set
  output logic req_done, // Pulse: last data phase taken
  output logic addr_trap, // Pulse: address trap
  output logic illegal_op, // Pulse: illegal instruction
  output logic mem_valid, // Data phase offered to memory bus
  input wire logic mem_ready, // Memory bus takes the phase
  output logic [31:0] mem_addr, // Physical address of phase
  output logic [1:0] mem_width, // Port width code of region
  output logic mem_write, // Phase is a store
  output logic mem_cached, // Access goes through cache
  output logic mem_last, // Final phase of the access
  output logic irq, // Level interrupt
  input wire logic awvalid, // AXI write address valid
  output logic awready, // AXI write address ready
  input wire logic [7:0] awaddr, // AXI write address
  input wire logic wvalid, // AXI write data valid
  output logic wready, // AXI write data ready
  input wire logic [31:0] wdata, // AXI write data
  input wire logic [3:0] wstrb, // AXI byte strobes
  output logic bvalid, // AXI write response valid
  input wire logic bready, // AXI write response ready
  output logic [1:0] bresp, // AXI write response
  input wire logic arvalid, // AXI read address valid
  output logic arready, // AXI read address ready
  input wire logic [7:0] araddr, // AXI read address
  output logic rvalid, // AXI read data valid
  input wire logic rready, // AXI read data ready
  output logic [31:0] rdata, // AXI read data
  output logic [1:0] rresp // AXI read response
);
  logic aw_got, next_aw_got, w_got, next_w_got;
  logic [7:0] wa, next_wa;
  logic [31:0] wd, next_wd;
  logic [3:0] ws, next_ws;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic [27:0] width_cfg, next_width_cfg;
  logic cop_user_en, next_cop_user_en;
  logic [1:0] status, next_status, mask, next_mask;
  logic next_irq;
  segmap_pkg::xfer_state_t state, next_state;
  logic mode_usr, next_mode_usr;
  logic next_req_ready, next_req_done, next_addr_trap, next_illegal_op;
  logic next_mem_valid, next_mem_write, next_mem_cached, next_mem_last;
  logic [31:0] next_mem_addr, phys;
  logic [1:0] next_mem_width, left, next_left, n_left, pw;
  logic [2:0] step, next_step, n_step;
  logic [3:0] sub;
  logic cached, acc, bad_op, bad_addr;

  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Register bus and interrupt
  always_comb begin
    logic [31:0] v;
    v = 32'h00000000;
    next_aw_got = aw_got;
    next_w_got = w_got;
    next_wa = wa;
    next_wd = wd;
    next_ws = ws;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    next_width_cfg = width_cfg;
    next_cop_user_en = cop_user_en;
    next_mask = mask;
    next_status = status;
    if (awvalid && awready) begin
      next_aw_got = 1'b1;
      next_wa = awaddr;
    end
    if (wvalid && wready) begin
      next_w_got = 1'b1;
      next_wd = wdata;
      next_ws = wstrb;
    end
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    if (aw_got && w_got && !bvalid) begin
      next_aw_got = 1'b0;
      next_w_got = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = segmap_pkg::RESP_OKAY;
      unique case (wa)
        segmap_pkg::WIDTH_OFS: begin
          v = merge({4'h0, width_cfg}, wd, ws);
          next_width_cfg = v[27:0]; // R16
        end
        segmap_pkg::CTRL_OFS: begin
          v = merge({31'h0, cop_user_en}, wd, ws);
          next_cop_user_en = v[0];
        end
        segmap_pkg::MASK_OFS: begin
          v = merge({30'h0, mask}, wd, ws);
          next_mask = v[1:0];
        end
        segmap_pkg::STATUS_OFS, segmap_pkg::STATE_OFS: begin
        end
        default: next_bresp = segmap_pkg::RESP_SLVERR;
      endcase
    end
    if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rresp = segmap_pkg::RESP_OKAY;
      unique case (araddr)
        segmap_pkg::WIDTH_OFS: next_rdata = {4'h0, width_cfg};
        segmap_pkg::CTRL_OFS: next_rdata = {31'h0, cop_user_en};
        segmap_pkg::MASK_OFS: next_rdata = {30'h0, mask};
        segmap_pkg::STATE_OFS: begin
          next_rdata = {30'h0, state == segmap_pkg::ST_BUSY, mode_usr};
        end
        segmap_pkg::STATUS_OFS: begin
          next_rdata = {30'h0, status};
          next_status = 2'h0;
        end
        default: begin
          next_rdata = 32'h00000000;
          next_rresp = segmap_pkg::RESP_SLVERR;
        end
      endcase
    end
    // New events win over a clearing read
    next_status[segmap_pkg::EV_TRAP] =
      next_status[segmap_pkg::EV_TRAP] | addr_trap;
    next_status[segmap_pkg::EV_ILL] =
      next_status[segmap_pkg::EV_ILL] | illegal_op;
    next_irq = |(next_status & next_mask);
    next_awready = !next_aw_got && !next_bvalid;
    next_wready = !next_w_got && !next_bvalid;
    next_arready = !next_rvalid;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      wa <= 8'h00;
      wd <= 32'h00000000;
      ws <= 4'h0;
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= segmap_pkg::RESP_OKAY;
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= segmap_pkg::RESP_OKAY;
      width_cfg <= segmap_pkg::WIDTH_RST;
      cop_user_en <= segmap_pkg::CTRL_RST;
      mask <= segmap_pkg::MASK_RST;
      status <= 2'h0;
      irq <= 1'b0;
    end else begin
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      wa <= next_wa;
      wd <= next_wd;
      ws <= next_ws;
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      arready <= next_arready;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      width_cfg <= next_width_cfg;
      cop_user_en <= next_cop_user_en;
      mask <= next_mask;
      status <= next_status;
      irq <= next_irq;
    end
  end

  // Translation, protection and data phase sequencing
  always_comb begin
    acc = req_valid && req_ready;
    bad_op = mode_usr && (req_priv || (req_cop && !cop_user_en)); // R01
    bad_addr = mode_usr && req_addr[31]; // R14
    // Segment decode ignores the mode bit
    if (!req_addr[31]) begin // R02
      phys = req_addr + segmap_pkg::USER_OFFSET; // R04 R06
      sub = segmap_pkg::SUB_USER + {2'h0, req_addr[30:29]}; // R10
    end else if (!req_addr[30]) begin
      phys = {3'h0, req_addr[28:0]}; // R03 R12 R13
      sub = {1'b0, req_addr[28:26]}; // R09
    end else begin
      phys = req_addr; // R05
      sub = segmap_pkg::SUB_MAPPED + {3'h0, req_addr[29]}; // R11
    end
    cached = req_addr[31:29] == 3'h4; // R12
    pw = width_cfg[{sub, 1'b0} +: 2]; // R16
    n_left = 2'h0;
    n_step = 3'h4;
    if (pw == segmap_pkg::PW8) begin // R07 R08
      n_step = 3'h1;
      n_left = req_size == segmap_pkg::SZ_W ? 2'h3 :
               req_size == segmap_pkg::SZ_H ? 2'h1 : 2'h0;
    end else if (pw == segmap_pkg::PW16) begin
      n_step = 3'h2;
      n_left = req_size == segmap_pkg::SZ_W ? 2'h1 : 2'h0;
    end
    next_state = state;
    next_mode_usr = user_mode;
    next_left = left;
    next_step = step;
    next_mem_valid = mem_valid;
    next_mem_addr = mem_addr;
    next_mem_width = mem_width;
    next_mem_write = mem_write;
    next_mem_cached = mem_cached;
    next_mem_last = mem_last;
    next_req_done = 1'b0;
    next_addr_trap = 1'b0;
    next_illegal_op = 1'b0;
    unique case (state)
      segmap_pkg::ST_IDLE: begin
        if (acc && bad_op) begin
          next_illegal_op = 1'b1; // R01
        end else if (acc && bad_addr) begin
          next_addr_trap = 1'b1; // R14
        end else if (acc) begin
          next_state = segmap_pkg::ST_BUSY;
          next_mem_valid = 1'b1;
          next_mem_addr = phys;
          next_mem_width = pw;
          next_mem_write = req_write;
          next_mem_cached = cached;
          next_mem_last = n_left == 2'h0;
          next_left = n_left;
          next_step = n_step;
        end
      end
      segmap_pkg::ST_BUSY: begin
        if (mem_ready) begin
          if (left == 2'h0) begin
            next_state = segmap_pkg::ST_IDLE;
            next_mem_valid = 1'b0;
            next_mem_last = 1'b0;
            next_req_done = 1'b1;
          end else begin
            next_left = left - 2'h1; // R07
            next_mem_addr = mem_addr + {29'h0, step};
            next_mem_last = left == 2'h1;
          end
        end
      end
    endcase
    next_req_ready = next_state == segmap_pkg::ST_IDLE;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= segmap_pkg::ST_IDLE;
      mode_usr <= 1'b0; // R15
      req_ready <= 1'b1;
      req_done <= 1'b0;
      addr_trap <= 1'b0;
      illegal_op <= 1'b0;
      mem_valid <= 1'b0;
      mem_addr <= 32'h00000000;
      mem_width <= segmap_pkg::PW32;
      mem_write <= 1'b0;
      mem_cached <= 1'b0;
      mem_last <= 1'b0;
      left <= 2'h0;
      step <= 3'h4;
    end else begin
      state <= next_state;
      mode_usr <= next_mode_usr;
      req_ready <= next_req_ready;
      req_done <= next_req_done;
      addr_trap <= next_addr_trap;
      illegal_op <= next_illegal_op;
      mem_valid <= next_mem_valid;
      mem_addr <= next_mem_addr;
      mem_width <= next_mem_width;
      mem_write <= next_mem_write;
      mem_cached <= next_mem_cached;
      mem_last <= next_mem_last;
      left <= next_left;
      step <= next_step;
    end
  end

  sequence s_take;
    req_valid && req_ready;
  endsequence
  sequence s_good;
    s_take and (!bad_op && !bad_addr);
  endsequence

  property p_illegal;
    @(posedge clk) disable iff (rst)
    s_take and bad_op |=> illegal_op && !mem_valid;
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal op lost"); // R01
  property p_trap;
    @(posedge clk) disable iff (rst)
    s_take and (mode_usr && req_addr[31] && !bad_op) |=>
      addr_trap && !mem_valid;
  endproperty
  a_trap: assert property (p_trap) else $error("user trap missing"); // R14
  property p_user;
    @(posedge clk) disable iff (rst)
    s_good and !req_addr[31] |=>
      mem_valid && mem_addr == $past(req_addr) + segmap_pkg::USER_OFFSET;
  endproperty
  a_user: assert property (p_user) else $error("user offset wrong"); // R04
  property p_cached;
    @(posedge clk) disable iff (rst)
    s_good and req_addr[31:29] == 3'h4 |=>
      mem_cached && mem_addr == {1'b0, $past(req_addr[30:0])};
  endproperty
  a_cached: assert property (p_cached) else $error("cached map wrong"); // R12
  property p_uncached;
    @(posedge clk) disable iff (rst)
    s_good and req_addr[31:29] == 3'h5 |=>
      !mem_cached && mem_addr == {3'h0, $past(req_addr[28:0])};
  endproperty
  a_uncached: assert property (p_uncached) // R13
    else $error("uncached map wrong");
  property p_mapped;
    @(posedge clk) disable iff (rst)
    s_good and req_addr[31:30] == 2'h3 |=> mem_addr == $past(req_addr);
  endproperty
  a_mapped: assert property (p_mapped) // R05
    else $error("mapped addr changed");
  property p_gap;
    @(posedge clk) disable iff (rst)
    mem_valid |->
      !(mem_addr >= segmap_pkg::GAP_LO && mem_addr <= segmap_pkg::GAP_HI);
  endproperty
  a_gap: assert property (p_gap) else $error("gap address issued"); // R06
  property p_split8;
    @(posedge clk) disable iff (rst)
    s_good and (pw == segmap_pkg::PW8 && req_size == segmap_pkg::SZ_W) |=>
      mem_valid && !mem_last && mem_width == segmap_pkg::PW8;
  endproperty
  a_split8: assert property (p_split8) else $error("no byte split"); // R07
  property p_reset;
    @(posedge clk) rst |=> !mode_usr && req_ready && !mem_valid;
  endproperty
  a_reset: assert property (p_reset) else $error("reset not kernel"); // R15
endmodule
`default_nettype wire

// file: mem_model.sv
// Memory bus responder that takes each phase after a set stall
`timescale 1ns/10ps
`default_nettype none
module mem_model (
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic [1:0] stall, // Wait cycles per phase, less one
  input wire logic mem_valid, // Phase offered
  output var logic mem_ready // Phase taken
);
  logic [1:0] cnt;
  always_ff @(posedge clk) begin
    if (rst || !mem_valid || mem_ready) begin
      cnt <= 2'h0;
      mem_ready <= 1'b0;
    end else begin
      cnt <= cnt + 2'h1;
      mem_ready <= (cnt >= stall);
    end
  end
endmodule
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the program address segment map
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic user_mode = 1'b0, req_valid = 1'b0, req_write = 1'b0;
  logic req_cop = 1'b0, req_priv = 1'b0, mem_ready;
  logic [31:0] req_addr = 32'h0, wdata = 32'h0, rdata, mem_addr, rd;
  logic [1:0] req_size = 2'h2, stall = 2'h0, bresp, rresp, mem_width;
  logic req_ready, req_done, addr_trap, illegal_op, mem_valid, mem_write;
  logic mem_cached, mem_last, irq, awready, wready, bvalid, arready;
  logic rvalid, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [3:0] wstrb = 4'hF;
  int n_fail = 0, checked = 0, cyc = 0, n_ph;
  logic [31:0] ph_addr [0:3];
  logic [1:0] resp, ph_w;
  logic ph_c, ph_wr, got_trap, got_ill, got_done, got_busy;

  segment_map segment_map_inst (.clk, .rst, .user_mode, .req_valid,
    .req_ready, .req_addr, .req_size, .req_write, .req_cop, .req_priv,
    .req_done, .addr_trap, .illegal_op, .mem_valid, .mem_ready, .mem_addr,
    .mem_width, .mem_write, .mem_cached, .mem_last, .irq, .awvalid,
    .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready,
    .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp);
  mem_model mem_model_inst (.clk, .rst, .stall, .mem_valid, .mem_ready);

  always #50 clk = ~clk;

  task automatic finish_test();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("Error %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk);
      if (!aw && awready === 1'b1) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w && wready === 1'b1) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge clk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge clk); while (rvalid !== 1'b1);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic set_mode(input logic m);
    user_mode <= m;
    repeat (2) @(posedge clk);
  endtask

  // Issue one access and collect every data phase until the last one
  task automatic acc(input logic [31:0] a, input logic [1:0] sz);
    n_ph = 0;
    got_done = 1'b0;
    req_addr <= a;
    req_size <= sz;
    req_valid <= 1'b1;
    do @(posedge clk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    @(posedge clk);
    got_trap = addr_trap;
    got_ill = illegal_op;
    got_busy = req_ready;
    ph_w = mem_width;
    ph_c = mem_cached;
    ph_wr = mem_write;
    if (mem_valid === 1'b1) begin
      forever begin
        if (mem_valid === 1'b1 && mem_ready === 1'b1) begin
          ph_addr[n_ph] = mem_addr;
          n_ph++;
          if (mem_last === 1'b1 || n_ph == 4) break;
        end
        @(posedge clk);
      end
      @(posedge clk);
      got_done = req_done;
    end
  endtask

  task automatic t_reset();
    axr(segmap_pkg::STATE_OFS);
    chk(32'(rd[0]), 32'h0);
    axr(segmap_pkg::WIDTH_OFS);
    chk(rd, 32'(segmap_pkg::WIDTH_RST));
    axr(segmap_pkg::CTRL_OFS);
    chk(rd, 32'(segmap_pkg::CTRL_RST));
    axr(segmap_pkg::MASK_OFS);
    chk(rd, 32'(segmap_pkg::MASK_RST));
    chk(32'(irq), 32'h0);
    $display("test reset done");
  endtask

  task automatic t_xlat();
    logic [31:0] va [9] = '{32'h00001234, 32'h00001234, 32'h7FFFFFFC,
      32'h9FFFFFFC, 32'hBFC00000, 32'hC0000000, 32'hFFFFFFFC,
      32'h80000000, 32'hC0000000};
    logic [31:0] pa [9] = '{32'h40001234, 32'h40001234, 32'hBFFFFFFC,
      32'h1FFFFFFC, 32'h1FC00000, 32'hC0000000, 32'hFFFFFFFC,
      32'h0, 32'h0};
    logic um [9] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    for (int i = 0; i < 9; i++) begin
      set_mode(um[i]);
      acc(va[i], segmap_pkg::SZ_W);
      chk(32'(got_trap), 32'(um[i] & va[i][31]));
      if (!(um[i] && va[i][31])) begin
        chk(ph_addr[0], pa[i]);
        chk(32'(ph_addr[0] >= segmap_pkg::GAP_LO &&
          ph_addr[0] <= segmap_pkg::GAP_HI), 32'h0);
        if (va[i][31:30] == 2'h2) begin
          chk(32'(ph_c), 32'(!va[i][29]));
        end
      end
    end
    set_mode(1'b0);
    $display("test xlat done");
  endtask

  task automatic t_width();
    logic [31:0] va [8] = '{32'h80000010, 32'h80000010, 32'h80000010,
      32'hA4000020, 32'hA4000020, 32'h20000100, 32'hC0000040,
      32'hE0000040};
    logic [31:0] pa [8] = '{32'h10, 32'h10, 32'h10, 32'h04000020,
      32'h04000020, 32'h60000100, 32'hC0000040, 32'hE0000040};
    logic [1:0] sz [8] = '{2'h2, 2'h1, 2'h0, 2'h2, 2'h1, 2'h2, 2'h2, 2'h2};
    int np [8] = '{4, 2, 1, 2, 1, 2, 4, 1};
    int st [8] = '{1, 1, 1, 2, 2, 2, 1, 0};
    logic [1:0] wc [8] = '{segmap_pkg::PW8, segmap_pkg::PW8,
      segmap_pkg::PW8, segmap_pkg::PW16, segmap_pkg::PW16,
      segmap_pkg::PW16, segmap_pkg::PW8, segmap_pkg::PW32};
    axw(segmap_pkg::WIDTH_OFS, 32'h02040006);
    chk(32'(resp), 32'(segmap_pkg::RESP_OKAY));
    stall <= 2'h2;
    for (int i = 0; i < 8; i++) begin
      req_write <= i[0];
      acc(va[i], sz[i]);
      chk(32'(n_ph), 32'(np[i]));
      chk(32'(ph_w), 32'(wc[i]));
      chk(ph_addr[0], pa[i]);
      chk(ph_addr[n_ph - 1], pa[i] + 32'(st[i] * (np[i] - 1)));
      chk(32'(ph_wr), 32'(i[0]));
      chk(32'({got_done, got_busy}), 32'h2);
    end
    req_write <= 1'b0;
    axw(segmap_pkg::WIDTH_OFS, 32'h0);
    acc(32'h80000010, segmap_pkg::SZ_W);
    chk(32'(n_ph), 32'h1);
    stall <= 2'h0;
    $display("test width done");
  endtask

  task automatic t_ill();
    set_mode(1'b1);
    axr(segmap_pkg::STATE_OFS);
    chk(32'(rd[0]), 32'h1);
    req_priv <= 1'b1;
    acc(32'h100, segmap_pkg::SZ_W);
    chk(32'({got_ill, 3'(n_ph)}), 32'h8);
    req_priv <= 1'b0;
    req_cop <= 1'b1;
    acc(32'h100, segmap_pkg::SZ_W);
    chk(32'({got_ill, 3'(n_ph)}), 32'h8);
    axw(segmap_pkg::CTRL_OFS, 32'h1);
    acc(32'h100, segmap_pkg::SZ_W);
    chk(32'({got_ill, 3'(n_ph)}), 32'h1);
    req_cop <= 1'b0;
    req_priv <= 1'b1;
    set_mode(1'b0);
    acc(32'h100, segmap_pkg::SZ_W);
    chk(32'({got_ill, 3'(n_ph)}), 32'h1);
    req_priv <= 1'b0;
    $display("test illegal done");
  endtask

  task automatic t_irq();
    chk(32'(irq), 32'h0);
    axw(segmap_pkg::MASK_OFS, 32'h2);
    chk(32'(irq), 32'h1);
    axr(segmap_pkg::STATUS_OFS);
    chk(rd, 32'h3);
    @(posedge clk);
    chk(32'(irq), 32'h0);
    axr(segmap_pkg::STATUS_OFS);
    chk(rd, 32'h0);
    axr(8'h40);
    chk({rd[29:0], resp}, 32'(segmap_pkg::RESP_SLVERR));
    axw(8'h40, 32'h5);
    chk(32'(resp), 32'(segmap_pkg::RESP_SLVERR));
    $display("test irq done");
  endtask

  // Mid-run reset with user mode held: first access must see kernel mode
  task automatic t_rst();
    user_mode <= 1'b1;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    acc(32'hA0000000, segmap_pkg::SZ_W);
    chk(32'({got_trap, 3'(n_ph)}), 32'h1);
    chk(ph_addr[0], 32'h00000000);
    acc(32'hA0000000, segmap_pkg::SZ_W);
    chk(32'({got_trap, 3'(n_ph)}), 32'h8);
    set_mode(1'b0);
    axr(segmap_pkg::CTRL_OFS);
    chk(rd, 32'(segmap_pkg::CTRL_RST));
    $display("test reset again done");
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_xlat();
    t_width();
    t_ill();
    t_irq();
    t_rst();
    finish_test();
  end
endmodule
`default_nettype wire
